/* File: mpmfc_pkg.sv */
// Constants shared by the PHY management and flow control register block.
// Assumes a 200 MHz aclk and a 32-bit AXI4-Lite register port.
package mpmfc_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_PHY_MGMT_ACCESS    = 12'h114;
   localparam logic [11:0] OFS_PHY_MGMT_DATA      = 12'h118;
   localparam logic [11:0] OFS_PAUSE_FLOW_CONTROL = 12'h11C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ACC_PHY_ADDR_LSB = 11;
   localparam int ACC_REG_IDX_LSB  = 6;
   localparam int ACC_WNR_BIT      = 1;
   localparam int ACC_BUSY_BIT     = 0;
   localparam int FLOW_PT_LSB      = 16;
   localparam int FLOW_PASS_BIT    = 2;
   localparam int FLOW_EN_BIT      = 1;
   localparam int FLOW_BUSY_BIT    = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [4:0]  RST_PHY_ADDR   = 5'h00;
   localparam logic [4:0]  RST_REG_IDX    = 5'h00;
   localparam logic [15:0] RST_PHY_DATA   = 16'h0000;
   localparam logic [15:0] RST_PAUSE_TIME = 16'h0000;

   // ----------------------------------------------------------------
   // AXI responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Timing: one pause quantum is one slot time (512 bit times)
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 5000;
   localparam int SLOT_TIME_100_NS = 5120;
   localparam int SLOT_TIME_10_NS  = 51200;
   localparam int SLOT_CYC_100    = (SLOT_TIME_100_NS * 1000) / CLK_PERIOD_PS;
   localparam int SLOT_CYC_10     = (SLOT_TIME_10_NS * 1000) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {MG_IDLE, MG_REQ, MG_DONE} mpmfc_mg_state_t;

endpackage

/* File: mpmfc_mgmt_if.sv */
// Carrier between the register front end and the PHY management engine.
// Assumes both ends run on the same aclk.
`timescale 1ns/1ps
`default_nettype none
interface mpmfc_mgmt_if;
   logic        start;
   logic        write;
   logic [4:0]  phy_addr;
   logic [4:0]  reg_idx;
   logic [15:0] wdata;
   logic        done;
   logic [15:0] rdata;
   modport ctrl (output start, output write, output phy_addr, output reg_idx,
                 output wdata, input done, input rdata);
   modport eng  (input start, input write, input phy_addr, input reg_idx,
                 input wdata, output done, output rdata);
endinterface
`default_nettype wire

/* File: mpmfc_mgmt.sv */
// PHY management engine: one request/acknowledge cycle per start pulse.
// Assumes the internal PHY register port shares aclk and answers with a
// one-cycle ack, carrying read data in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module mpmfc_mgmt
   import mpmfc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   mpmfc_mgmt_if.eng        mg,
   output logic             phy_req,
   output logic             phy_write,
   output logic [4:0]       phy_addr,
   output logic [4:0]       phy_reg,
   output logic [15:0]      phy_wdata,
   input  wire logic        phy_ack,
   input  wire logic [15:0] phy_rdata
);
   mpmfc_mg_state_t state_r;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r   <= MG_IDLE;
         phy_req   <= 1'b0;
         phy_write <= 1'b0;
         phy_addr  <= RST_PHY_ADDR;
         phy_reg   <= RST_REG_IDX;
         phy_wdata <= RST_PHY_DATA;
         mg.done   <= 1'b0;
         mg.rdata  <= RST_PHY_DATA;
      end else begin
         mg.done <= 1'b0;
         case (state_r)
            MG_IDLE: begin
               if (mg.start) begin
                  // Fields frozen here so later register writes cannot disturb the cycle
                  phy_req   <= 1'b1;
                  phy_write <= mg.write;
                  phy_addr  <= mg.phy_addr;
                  phy_reg   <= mg.reg_idx;
                  phy_wdata <= mg.wdata;
                  state_r   <= MG_REQ;
               end
            end
            MG_REQ: begin
               if (phy_ack) begin
                  phy_req  <= 1'b0;
                  mg.rdata <= phy_rdata;
                  state_r  <= MG_DONE;
               end
            end
            MG_DONE: begin
               mg.done <= 1'b1;
               state_r <= MG_IDLE;
            end
            default: state_r <= MG_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: mpmfc_top.sv */
// PHY management access and flow control register block.
// Assumes AXI4-Lite on aclk and MAC datapath strobes on the same clock.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mpmfc_top
   import mpmfc_pkg::*;
#(
   parameter int SLOT_CYCLES_10M = SLOT_CYC_10
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             phy_req,
   output logic             phy_write,
   output logic [4:0]       phy_addr,
   output logic [4:0]       phy_reg,
   output logic [15:0]      phy_wdata,
   input  wire logic        phy_ack,
   input  wire logic [15:0] phy_rdata,
   input  wire logic        full_duplex,
   input  wire logic        speed_100,
   input  wire logic        promiscuous,
   input  wire logic        rx_frame_end,
   input  wire logic        rx_addr_pass,
   input  wire logic        rx_frame_error,
   input  wire logic        rx_pause_frame,
   input  wire logic [15:0] rx_pause_quanta,
   output logic             rx_status_valid,
   output logic             rx_status_filter,
   output logic             rx_status_error,
   input  wire logic        pause_send_req,
   input  wire logic        tx_pause_done,
   input  wire logic        backpressure_req,
   output logic             tx_pause_frame,
   output logic [15:0]      tx_pause_time,
   output logic             tx_stall,
   output logic             backpressure
);
   mpmfc_mgmt_if mg ();

   logic [4:0]  phy_addr_r;
   logic [4:0]  reg_idx_r;
   logic        wnr_r;
   logic        mgmt_busy_r;
   logic [15:0] mgmt_data_r;
   logic [15:0] pause_time_r;
   logic        pass_ctrl_r;
   logic        fc_en_r;
   logic        aw_held_r;
   logic        w_held_r;
   logic [11:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        wr_fire;
   logic [15:0] quanta_r;
   logic [13:0] slot_cnt_r;
   logic        pause_act;
   logic        fc_busy;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return (a == OFS_PHY_MGMT_ACCESS) || (a == OFS_PHY_MGMT_DATA) ||
             (a == OFS_PAUSE_FLOW_CONTROL);
   endfunction

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   // Address and data are taken in either order; the write lands once both are held
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         awaddr_r      <= 12'h000;
         wdata_r       <= 32'h00000000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r     <= 1'b1;
            awaddr_r      <= {s_axi_awaddr[11:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r     <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Management access and data registers
   // ----------------------------------------------------------------
   // Writes while busy are dropped so an access in flight keeps its fields
   always_ff @(posedge aclk) begin
      logic [31:0] v;
      v = merge({16'h0000, phy_addr_r, reg_idx_r, 4'h0, wnr_r, mgmt_busy_r},
                wdata_r, wstrb_r);
      if (!aresetn) begin
         phy_addr_r  <= RST_PHY_ADDR;
         reg_idx_r   <= RST_REG_IDX;
         wnr_r       <= 1'b0;
         mgmt_busy_r <= 1'b0;
         mg.start    <= 1'b0;
      end else begin
         mg.start <= 1'b0;
         if (mg.done) begin
            mgmt_busy_r <= 1'b0;
         end
         if (wr_fire && awaddr_r == OFS_PHY_MGMT_ACCESS && !mgmt_busy_r) begin
            phy_addr_r <= v[ACC_PHY_ADDR_LSB +: 5];
            reg_idx_r  <= v[ACC_REG_IDX_LSB +: 5];
            wnr_r      <= v[ACC_WNR_BIT];
            if (v[ACC_BUSY_BIT]) begin
               mgmt_busy_r <= 1'b1;
               mg.start    <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mgmt_data_r <= RST_PHY_DATA;
      end else if (mg.done && !wnr_r) begin
         mgmt_data_r <= mg.rdata;
      end else if (wr_fire && awaddr_r == OFS_PHY_MGMT_DATA && !mgmt_busy_r) begin
         mgmt_data_r <= 16'(merge({16'h0000, mgmt_data_r}, wdata_r, wstrb_r));
      end
   end

   assign mg.write    = wnr_r;
   assign mg.phy_addr = phy_addr_r;
   assign mg.reg_idx  = reg_idx_r;
   assign mg.wdata    = mgmt_data_r;

   mpmfc_mgmt u_mgmt (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .mg        (mg),
      .phy_req   (phy_req),
      .phy_write (phy_write),
      .phy_addr  (phy_addr),
      .phy_reg   (phy_reg),
      .phy_wdata (phy_wdata),
      .phy_ack   (phy_ack),
      .phy_rdata (phy_rdata)
   );

   // ----------------------------------------------------------------
   // Flow control register
   // ----------------------------------------------------------------
   // The busy bit is owned by hardware; its written value is discarded
   always_ff @(posedge aclk) begin
      logic [31:0] v;
      v = merge({pause_time_r, 13'h0000, pass_ctrl_r, fc_en_r, 1'b0}, wdata_r, wstrb_r);
      if (!aresetn) begin
         pause_time_r <= RST_PAUSE_TIME;
         pass_ctrl_r  <= 1'b0;
         fc_en_r      <= 1'b0;
      end else if (wr_fire && awaddr_r == OFS_PAUSE_FLOW_CONTROL) begin
         pause_time_r <= v[FLOW_PT_LSB +: 16];
         pass_ctrl_r  <= v[FLOW_PASS_BIT];
         fc_en_r      <= v[FLOW_EN_BIT];
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         case ({s_axi_araddr[11:2], 2'b00})
            OFS_PHY_MGMT_ACCESS:
               s_axi_rdata <= {16'h0000, phy_addr_r, reg_idx_r, 4'h0, wnr_r,
                               mgmt_busy_r};
            OFS_PHY_MGMT_DATA:
               s_axi_rdata <= {16'h0000, mgmt_data_r};
            OFS_PAUSE_FLOW_CONTROL:
               s_axi_rdata <= {pause_time_r, 13'h0000, pass_ctrl_r, fc_en_r, fc_busy};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Pause frame generation and back pressure
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_pause_frame <= 1'b0;
         tx_pause_time  <= RST_PAUSE_TIME;
         backpressure   <= 1'b0;
      end else begin
         if (tx_pause_frame && tx_pause_done) begin
            tx_pause_frame <= 1'b0;
         end else if (pause_send_req && fc_en_r && full_duplex && !tx_pause_frame) begin
            tx_pause_frame <= 1'b1;
            tx_pause_time  <= pause_time_r;
         end
         backpressure <= fc_en_r && !full_duplex && backpressure_req;
      end
   end

   assign fc_busy = tx_pause_frame || backpressure;

   // ----------------------------------------------------------------
   // Received pause: stall for quanta times slot time
   // ----------------------------------------------------------------
   assign pause_act = rx_frame_end && rx_pause_frame && !rx_frame_error &&
                      fc_en_r && full_duplex;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         quanta_r   <= 16'h0000;
         slot_cnt_r <= 14'h0000;
         tx_stall   <= 1'b0;
      end else begin
         if (pause_act) begin
            // A new pause replaces the remaining time, as a zero quanta resumes at once
            quanta_r   <= rx_pause_quanta;
            slot_cnt_r <= 14'h0000;
            tx_stall   <= (rx_pause_quanta != 16'h0000);
         end else if (quanta_r != 16'h0000) begin
            if (slot_cnt_r == (speed_100 ? 14'(SLOT_CYC_100 - 1)
                                         : 14'(SLOT_CYCLES_10M - 1))) begin
               slot_cnt_r <= 14'h0000;
               quanta_r   <= quanta_r - 16'h0001;
               tx_stall   <= (quanta_r != 16'h0001);
            end else begin
               slot_cnt_r <= slot_cnt_r + 14'h0001;
            end
         end else begin
            tx_stall <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive status: every frame passes with a filter verdict
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_status_valid  <= 1'b0;
         rx_status_filter <= 1'b0;
         rx_status_error  <= 1'b0;
      end else begin
         rx_status_valid <= rx_frame_end;
         if (rx_frame_end) begin
            rx_status_error <= rx_frame_error;
            if (promiscuous) begin
               rx_status_filter <= 1'b1;
            end else if (rx_pause_frame && !rx_frame_error) begin
               rx_status_filter <= pass_ctrl_r;
            end else begin
               rx_status_filter <= rx_addr_pass;
            end
         end
      end
   end

endmodule
`default_nettype wire

/* File: mpmfc_phy_model.sv */
// Behavioural internal PHY register file answering management cycles.
// Assumes the request/acknowledge handshake of mpmfc_top on aclk.
`timescale 1ns/1ps
`default_nettype none
module mpmfc_phy_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        phy_req,
   input  wire logic        phy_write,
   input  wire logic [4:0]  phy_reg,
   input  wire logic [15:0] phy_wdata,
   output logic             phy_ack,
   output logic [15:0]      phy_rdata
);
   logic [15:0] mem [32];
   logic [3:0]  wait_r;
   // Odd indices answer slowly; read data toggles outside the ack cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phy_ack   <= 1'b0;
         wait_r    <= 4'h0;
         phy_rdata <= 16'h0;
      end else begin
         phy_ack   <= 1'b0;
         phy_rdata <= ~phy_rdata;
         if (phy_req && !phy_ack && wait_r == (phy_reg[0] ? 4'h9 : 4'h0)) begin
            phy_ack <= 1'b1;
            wait_r  <= 4'h0;
            if (phy_write) mem[phy_reg] <= phy_wdata;
            else phy_rdata <= mem[phy_reg];
         end else if (phy_req && !phy_ack) begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: mpmfc_assertions.sv */
// Port checks of the PHY management and flow control block.
// Assumes binding into mpmfc_top, one clock, synchronous low reset.
`timescale 1ns/1ps
`default_nettype none
module mpmfc_assertions #(
   parameter int SLOT_CYCLES_10M = 8
)(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        phy_req,
   input wire logic        phy_write,
   input wire logic [4:0]  phy_reg,
   input wire logic        phy_ack,
   input wire logic        full_duplex,
   input wire logic        speed_100,
   input wire logic        promiscuous,
   input wire logic        rx_frame_end,
   input wire logic        rx_frame_error,
   input wire logic        rx_pause_frame,
   input wire logic [15:0] rx_pause_quanta,
   input wire logic        rx_status_valid,
   input wire logic        rx_status_filter,
   input wire logic        rx_status_error,
   input wire logic        tx_pause_done,
   input wire logic        backpressure_req,
   input wire logic        tx_pause_frame,
   input wire logic        tx_stall,
   input wire logic        backpressure
);
   // --------
   // Helpers
   // --------
   wire logic   good_pause = rx_frame_end && rx_pause_frame && !rx_frame_error && full_duplex;
   logic [31:0] cnt_r;
   logic [15:0] q_r;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Restarts on every decoded pause; the stall timer restarts only when flow control is also enabled
   always_ff @(posedge aclk) begin
      if (!aresetn || good_pause) begin
         cnt_r <= 32'h0;
         q_r   <= rx_pause_quanta;
      end else if (tx_stall) begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
   // --------
   // Properties
   // --------
   sequence seq_ack;
      phy_req && phy_ack;
   endsequence
   sequence seq_stall_start;
      !tx_stall ##1 tx_stall;
   endsequence
   AST_PHY_RELEASE: assert property (seq_ack |=> !phy_req [*3])
      else $error("phy request not released");
   AST_PHY_FIELDS: assert property (phy_req && !phy_ack |=> phy_req && $stable(phy_write)
      && $stable(phy_reg)) else $error("phy fields moved");
   AST_STALL_CAUSE: assert property (seq_stall_start |-> $past(good_pause))
      else $error("stall without pause");
   AST_STALL_LEN: assert property ($fell(tx_stall) && !speed_100 && $past(aresetn)
      |-> cnt_r == q_r * SLOT_CYCLES_10M) else $error("stall length");
   AST_FLOW_BUSY: assert property (tx_pause_frame && !tx_pause_done |=> tx_pause_frame)
      else $error("pause frame dropped");
   AST_BACKPRESSURE: assert property (backpressure |-> $past(backpressure_req && !full_duplex))
      else $error("backpressure cause");
   AST_RX_STATUS: assert property (rx_frame_end |=> rx_status_valid
      && rx_status_error == $past(rx_frame_error)) else $error("rx status");
   AST_PROMISC: assert property (rx_frame_end && promiscuous |=> rx_status_filter)
      else $error("promiscuous filter");
endmodule
bind mpmfc_top mpmfc_assertions #(.SLOT_CYCLES_10M(SLOT_CYCLES_10M)) mpmfc_assertions_i (.*);
`default_nettype wire

/* File: test_mac_phy_mgmt_flow_ctrl.sv */
// Self-checking bench for the PHY management and flow control block.
// Assumes mpmfc_top, the PHY model and the bound checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_mac_phy_mgmt_flow_ctrl;
   import mpmfc_pkg::*;
   localparam int SLOT10 = 8;
   logic        aclk = 1'b0, aresetn = 1'b0, pass_r = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, v;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        phy_req, phy_write, phy_ack, rx_status_valid, rx_status_filter;
   logic        rx_status_error, tx_pause_frame, tx_stall, backpressure;
   logic [4:0]  phy_addr, phy_reg, i5;
   logic [15:0] phy_wdata, phy_rdata, tx_pause_time, rx_pause_quanta = 16'h0;
   logic        full_duplex = 1'b0, speed_100 = 1'b0, promiscuous = 1'b0;
   logic        rx_frame_end = 1'b0, rx_addr_pass = 1'b0, rx_frame_error = 1'b0;
   logic        rx_pause_frame = 1'b0, pause_send_req = 1'b0, tx_pause_done = 1'b0;
   logic        backpressure_req = 1'b0;
   int          fail_count = 0, n_compared = 0, k, c;
   mpmfc_top #(.SLOT_CYCLES_10M(SLOT10)) mpmfc_top_i (.*);
   mpmfc_phy_model mpmfc_phy_model_i (.*);
   always #2.5 aclk = ~aclk;
   // --------
   // Tasks
   // --------
   task automatic wrap_up();
      if (fail_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 3000) begin
         fail_count++;
         wrap_up();
      end
   endtask
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         tick(n);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
   endtask
   task automatic axi_rd(input logic [11:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         tick(n);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   // Data write during busy is meant to be refused
   task automatic phy_op(input logic w, input logic [4:0] i, input logic [15:0] d);
      int n;
      n = 0;
      axi_wr(OFS_PHY_MGMT_ACCESS, {16'h0, 5'h01, i, 4'h0, w, 1'b1});
      while (phy_req !== 1'b1) tick(n);
      chk(32'({phy_write, phy_addr, phy_reg, phy_wdata | {16{~w}}}),
          32'({w, 5'h01, i, d | {16{~w}}}));
      axi_wr(OFS_PHY_MGMT_DATA, {16'h0, ~d});
      for (n = 0; n < 20; n++) begin
         axi_rd(OFS_PHY_MGMT_ACCESS);
         if (rd[0] === 1'b0) break;
      end
      chk(rd, {16'h0, 5'h01, i, 4'h0, w, 1'b0});
      axi_rd(OFS_PHY_MGMT_DATA);
      chk(rd, {16'h0, d});
   endtask
   function automatic logic filt(input logic [3:0] r);
      return r[3] | (r[0] ? pass_r : r[2]);
   endfunction
   // Bits of r: pause, error, address match, promiscuous
   task automatic frame(input logic [3:0] r);
      rx_pause_frame <= r[0];
      rx_frame_error <= r[1] & ~r[0];
      rx_addr_pass <= r[2];
      promiscuous <= r[3];
      rx_frame_end <= 1'b1;
      @(posedge aclk);
      rx_frame_end <= 1'b0;
      @(posedge aclk);
      chk(32'({rx_status_valid, rx_status_error, rx_status_filter}),
          32'({1'b1, r[1] & ~r[0], filt(r)}));
   endtask
   // --------
   // Sequence
   // --------
   initial begin
      void'($urandom(32'h350E));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (k = 0; k < 4; k++) begin
         axi_wr(12'(OFS_PHY_MGMT_ACCESS + 4 * k), 32'h0);
         chk(32'(rs), 32'(k == 3 ? RESP_SLVERR : RESP_OKAY));
         axi_rd(12'(OFS_PHY_MGMT_ACCESS + 4 * k));
         chk(rd, 32'h0);
         chk(32'(rs), 32'(k == 3 ? RESP_SLVERR : RESP_OKAY));
      end
      for (k = 0; k < 6; k++) begin
         v = $urandom;
         i5 = k == 0 ? 5'h00 : k == 1 ? 5'h1F : 5'($urandom);
         axi_wr(OFS_PHY_MGMT_DATA, v);
         axi_rd(OFS_PHY_MGMT_DATA);
         chk(rd, {16'h0, v[15:0]});
         phy_op(1'b1, i5, v[15:0]);
         axi_wr(OFS_PHY_MGMT_DATA, 32'h0);
         phy_op(1'b0, i5, v[15:0]);
      end
      v = $urandom;
      axi_wr(OFS_PAUSE_FLOW_CONTROL, v | 32'h7);
      axi_rd(OFS_PAUSE_FLOW_CONTROL);
      chk(rd, (v & 32'hFFFF0000) | 32'h6);
      full_duplex <= 1'b1;
      pause_send_req <= 1'b1;
      @(posedge aclk);
      pause_send_req <= 1'b0;
      @(posedge aclk);
      chk(32'({tx_pause_frame, tx_pause_time}), 32'({1'b1, v[31:16]}));
      axi_rd(OFS_PAUSE_FLOW_CONTROL);
      chk(32'(rd[0]), 32'h1);
      tx_pause_done <= 1'b1;
      @(posedge aclk);
      tx_pause_done <= 1'b0;
      full_duplex <= 1'b0;
      backpressure_req <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(32'({tx_pause_frame, backpressure}), 32'h1);
      backpressure_req <= 1'b0;
      repeat (2) @(posedge aclk);
      axi_rd(OFS_PAUSE_FLOW_CONTROL);
      chk(32'(rd[0]), 32'h0);
      for (k = 0; k < 4; k++) begin
         if (k == 3) axi_wr(OFS_PAUSE_FLOW_CONTROL, 32'h4);
         full_duplex <= (k != 2);
         speed_100 <= (k == 1);
         rx_pause_quanta <= (k == 1) ? 16'h1 : 16'h3;
         frame(4'h1);
         c = 0;
         while (tx_stall === 1'b1) tick(c);
         chk(32'(c), 32'(k == 0 ? 3 * SLOT10 : k == 1 ? SLOT_CYC_100 : 0));
      end
      axi_wr(OFS_PAUSE_FLOW_CONTROL, 32'h2);
      pass_r = 1'b0;
      full_duplex <= 1'b0;
      for (k = 0; k < 12; k++) frame(k == 0 ? 4'h9 : 4'($urandom));
      wrap_up();
   end
endmodule
`default_nettype wire
